// File: hw/pcra_pkg.sv
package pcra_pkg;
   // Register offsets (byte addresses, low 12 bits of haddr)
   localparam logic [11:0] OFF_STEP_CMD = 12'h100;
   localparam logic [11:0] OFF_SECONDS = 12'h110;
   localparam logic [11:0] OFF_NANOSECONDS = 12'h114;
   localparam logic [11:0] OFF_SUBNANOSECONDS = 12'h118;
   localparam logic [11:0] OFF_RATE_ADJUST = 12'h11c;
   localparam logic [11:0] OFF_TEMPORARY_RATE_ADJUST = 12'h120;
   localparam logic [11:0] OFF_TEMPORARY_RATE_DURATION = 12'h124;
   localparam logic [11:0] OFF_STEP_ADJUST = 12'h128;
   localparam int ADDR_W = 12;
   // Field layout
   localparam int DIR_BIT = 31;
   localparam int FRAC_W = 30;
   localparam int SEC_STEP_W = 4;
   localparam int CMD_STEP_SEC_BIT = 0;
   localparam int CMD_STEP_NS_BIT = 1;
   localparam int CMD_TEMP_ACTIVE_BIT = 2;
   // Timing: the clock tick equals the reference period
   localparam int REF_PERIOD_NS = 10;
   localparam logic [29:0] NS_NOMINAL = 30'(REF_PERIOD_NS);
   localparam logic [29:0] NS_SLOW = 30'(REF_PERIOD_NS - 1);
   localparam logic [29:0] NS_FAST = 30'(REF_PERIOD_NS + 1);
   localparam logic [30:0] NS_PER_SEC = 31'h3b9aca00;
   // Reset values and AHB encodings
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;

   typedef struct packed {
      logic pend;
      logic write;
      logic [11:0] addr;
      logic rd_wait;
      logic [31:0] rdata;
   } pcra_bus_s;

   typedef struct packed {
      logic [31:0] sec;
      logic [29:0] ns;
      logic [31:0] subns;
      logic rate_dir;
      logic [29:0] rate_frac;
      logic temp_dir;
      logic [29:0] temp_frac;
      logic [31:0] dur;
      logic [31:0] remain;
      logic step_dir;
      logic [29:0] step_amt;
      logic step_sec_pend;
      logic step_ns_pend;
   } pcra_core_s;
endpackage

// File: hw/pcra_ahb_slave.sv
`timescale 1ns/1ps
module pcra_ahb_slave (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_clk_en,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic i_hready,
   input wire logic [31:0] i_hwdata,
   input wire logic [31:0] i_rd_data,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic [11:0] o_addr,
   output logic o_wr_en,
   output logic [31:0] o_wr_data
);
   pcra_pkg::pcra_bus_s q, d;
   logic accept;

   // Reads take one wait state so that hrdata comes from a flop
   always_comb begin
      d = q;
      o_hreadyout = !(q.pend && !q.write && !q.rd_wait);
      accept = i_hsel && i_hready && ((i_htrans & pcra_pkg::HTRANS_NONSEQ_BIT) != 2'h0);
      if (!o_hreadyout) begin
         d.rdata = i_rd_data;
         d.rd_wait = 1'b1;
      end else begin
         d.pend = 1'b0;
         d.rd_wait = 1'b0;
      end
      if (accept) begin
         d.pend = 1'b1;
         d.write = i_hwrite;
         d.addr = i_haddr[pcra_pkg::ADDR_W-1:0];
         d.rd_wait = 1'b0;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q <= '0;
      end else if (i_clk_en) begin
         q <= d;
      end
   end

   assign o_hrdata = q.rdata;
   assign o_hresp = pcra_pkg::HRESP_OKAY;
   assign o_addr = q.addr;
   assign o_wr_en = q.pend && q.write;
   assign o_wr_data = i_hwdata;
endmodule // pcra_ahb_slave

// File: hw/pcra_rate_step.sv
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
module pcra_rate_step (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_clk_en,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic i_hready,
   input wire logic [31:0] i_hwdata,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic [31:0] o_seconds,
   output logic [29:0] o_nanoseconds,
   output logic [31:0] o_subnanoseconds,
   output logic o_temporary_active
);
   pcra_pkg::pcra_core_s q, d;
   logic [11:0] bus_addr;
   logic bus_wr_en;
   logic [31:0] bus_wr_data;
   logic [31:0] rd_data;
   logic temp_active;
   logic [29:0] frac_sel;
   logic dir_sel;
   logic [32:0] acc_sum;
   logic wrap;
   logic [29:0] inc_ns;
   logic [30:0] ns_sum;
   logic sec_carry;
   logic [31:0] sec_step;
   logic hsize_unused;

   ////////////////////////////////////////////////////////////////////////
   // Bus slave
   pcra_ahb_slave u_bus (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_clk_en(i_clk_en),
      .i_hsel(i_hsel),
      .i_haddr(i_haddr),
      .i_htrans(i_htrans),
      .i_hwrite(i_hwrite),
      .i_hready(i_hready),
      .i_hwdata(i_hwdata),
      .i_rd_data(rd_data),
      .o_hrdata(o_hrdata),
      .o_hreadyout(o_hreadyout),
      .o_hresp(o_hresp),
      .o_addr(bus_addr),
      .o_wr_en(bus_wr_en),
      .o_wr_data(bus_wr_data)
   );

   // Only whole-word transfers are used
   assign hsize_unused = ^i_hsize;

   ////////////////////////////////////////////////////////////////////////
   // Read mux, reserved bits and unmapped offsets read as zero
   always_comb begin
      rd_data = pcra_pkg::RESET_WORD;
      case (bus_addr)
         pcra_pkg::OFF_STEP_CMD: begin
            rd_data[pcra_pkg::CMD_STEP_SEC_BIT] = q.step_sec_pend;
            rd_data[pcra_pkg::CMD_STEP_NS_BIT] = q.step_ns_pend;
            rd_data[pcra_pkg::CMD_TEMP_ACTIVE_BIT] = temp_active;
         end
         pcra_pkg::OFF_SECONDS: begin
            rd_data = q.sec;
         end
         pcra_pkg::OFF_NANOSECONDS: begin
            rd_data[pcra_pkg::FRAC_W-1:0] = q.ns;
         end
         pcra_pkg::OFF_SUBNANOSECONDS: begin
            rd_data = q.subns;
         end
         pcra_pkg::OFF_RATE_ADJUST: begin
            rd_data[pcra_pkg::DIR_BIT] = q.rate_dir;
            rd_data[pcra_pkg::FRAC_W-1:0] = q.rate_frac;
         end
         pcra_pkg::OFF_TEMPORARY_RATE_ADJUST: begin
            rd_data[pcra_pkg::DIR_BIT] = q.temp_dir;
            rd_data[pcra_pkg::FRAC_W-1:0] = q.temp_frac;
         end
         pcra_pkg::OFF_TEMPORARY_RATE_DURATION: begin
            rd_data = q.dur;
         end
         pcra_pkg::OFF_STEP_ADJUST: begin
            rd_data[pcra_pkg::DIR_BIT] = q.step_dir;
            rd_data[pcra_pkg::FRAC_W-1:0] = q.step_amt;
         end
         default: begin
            rd_data = pcra_pkg::RESET_WORD;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Clock advance
   assign temp_active = (q.remain != 32'h0000_0000);

   always_comb begin
      d = q;
      // Temporary rate overrides the permanent one while counting
      frac_sel = temp_active ? q.temp_frac : q.rate_frac;
      dir_sel = temp_active ? q.temp_dir : q.rate_dir;
      acc_sum = {1'b0, q.subns} + {3'h0, frac_sel};
      wrap = acc_sum[32];
      d.subns = acc_sum[31:0];
      inc_ns = pcra_pkg::NS_NOMINAL;
      if (wrap) begin
         inc_ns = dir_sel ? pcra_pkg::NS_FAST : pcra_pkg::NS_SLOW;
      end
      // Nanosecond step always adds, direction ignored
      if (q.step_ns_pend) begin
         inc_ns = q.step_amt;
      end
      ns_sum = {1'b0, q.ns} + {1'b0, inc_ns};
      sec_carry = (ns_sum >= pcra_pkg::NS_PER_SEC);
      if (sec_carry) begin
         d.ns = 30'(ns_sum - pcra_pkg::NS_PER_SEC);
      end else begin
         d.ns = ns_sum[29:0];
      end
      sec_step = {28'h000_0000, q.step_amt[pcra_pkg::SEC_STEP_W-1:0]};
      d.sec = q.sec + {31'h0000_0000, sec_carry};
      if (q.step_sec_pend) begin
         if (q.step_dir) begin
            d.sec = q.sec + {31'h0000_0000, sec_carry} + sec_step;
         end else begin
            d.sec = q.sec + {31'h0000_0000, sec_carry} - sec_step;
         end
      end
      // Each trigger is consumed in the cycle it is applied
      d.step_sec_pend = 1'b0;
      d.step_ns_pend = 1'b0;
      if (temp_active) begin
         d.remain = q.remain - 32'h0000_0001;
      end
      // Software writes; a new trigger beats the consume above
      if (bus_wr_en) begin
         case (bus_addr)
            pcra_pkg::OFF_RATE_ADJUST: begin
               d.rate_dir = bus_wr_data[pcra_pkg::DIR_BIT];
               d.rate_frac = bus_wr_data[pcra_pkg::FRAC_W-1:0];
            end
            pcra_pkg::OFF_TEMPORARY_RATE_ADJUST: begin
               d.temp_dir = bus_wr_data[pcra_pkg::DIR_BIT];
               d.temp_frac = bus_wr_data[pcra_pkg::FRAC_W-1:0];
            end
            pcra_pkg::OFF_TEMPORARY_RATE_DURATION: begin
               d.dur = bus_wr_data;
               d.remain = bus_wr_data;
            end
            pcra_pkg::OFF_STEP_ADJUST: begin
               d.step_dir = bus_wr_data[pcra_pkg::DIR_BIT];
               d.step_amt = bus_wr_data[pcra_pkg::FRAC_W-1:0];
            end
            pcra_pkg::OFF_STEP_CMD: begin
               if (bus_wr_data[pcra_pkg::CMD_STEP_SEC_BIT]) begin
                  d.step_sec_pend = 1'b1;
               end
               if (bus_wr_data[pcra_pkg::CMD_STEP_NS_BIT]) begin
                  d.step_ns_pend = 1'b1;
               end
            end
            default: begin
               d.dur = q.dur;
            end
         endcase
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q <= '0;
      end else if (i_clk_en) begin
         q <= d;
      end
   end

   assign o_seconds = q.sec;
   assign o_nanoseconds = q.ns;
   assign o_subnanoseconds = q.subns;
   assign o_temporary_active = temp_active;

   ////////////////////////////////////////////////////////////////////////
   // Checks, sampled only on enabled edges
   localparam logic [29:0] NS_SAFE = 30'd999999000;

   default clocking cb @(posedge i_clock iff i_clk_en);
   endclocking
   default disable iff (!i_rst_n);

   logic plain_ns;
   // Reset term keeps the release edge, whose next state is still reset, out of the checks
   assign plain_ns = i_rst_n && !q.step_ns_pend && (q.ns < NS_SAFE);

   property p_nominal_tick;
      plain_ns && !wrap |=> q.ns == $past(q.ns) + 30'd10;
   endproperty
   a_nominal_tick: assert property (p_nominal_tick) else $error("ns did not advance by 10");

   property p_perm_slow;
      plain_ns && wrap && !temp_active && !q.rate_dir
         |=> q.ns == $past(q.ns) + 30'd9;
   endproperty
   a_perm_slow: assert property (p_perm_slow) else $error("slow wrap not 9 ns");

   property p_perm_fast;
      plain_ns && wrap && !temp_active && q.rate_dir
         |=> q.ns == $past(q.ns) + 30'd11;
   endproperty
   a_perm_fast: assert property (p_perm_fast) else $error("fast wrap not 11 ns");

   property p_perm_accumulate;
      !temp_active |=> q.subns == 32'($past(q.subns) + {2'h0, $past(q.rate_frac)});
   endproperty
   a_perm_accumulate: assert property (p_perm_accumulate) else $error("permanent add wrong");

   property p_temp_accumulate;
      temp_active |=> q.subns == 32'($past(q.subns) + {2'h0, $past(q.temp_frac)});
   endproperty
   a_temp_accumulate: assert property (p_temp_accumulate) else $error("temporary add wrong");

   property p_temp_wrap;
      plain_ns && wrap && temp_active
         |=> q.ns == $past(q.ns) + ($past(q.temp_dir) ? 30'd11 : 30'd9);
   endproperty
   a_temp_wrap: assert property (p_temp_wrap) else $error("temporary wrap increment wrong");

   property p_temp_dir_reset;
      $rose(i_rst_n) |-> !q.temp_dir && !q.rate_dir && q.dur == 32'h0;
   endproperty
   a_temp_dir_reset: assert property (p_temp_dir_reset) else $error("reset values wrong");

   sequence s_dur_two;
      bus_wr_en && bus_addr == pcra_pkg::OFF_TEMPORARY_RATE_DURATION
         && bus_wr_data == 32'h0000_0002;
   endsequence

   sequence s_two_active;
      !bus_wr_en ##0 temp_active [*2] ##1 !temp_active;
   endsequence

   property p_duration;
      s_dur_two ##1 !bus_wr_en |-> s_two_active;
   endproperty
   a_duration: assert property (p_duration) else $error("temporary duration wrong");

   property p_back_to_perm;
      !temp_active && !(bus_wr_en && bus_addr == pcra_pkg::OFF_TEMPORARY_RATE_DURATION)
         |=> !temp_active;
   endproperty
   a_back_to_perm: assert property (p_back_to_perm) else $error("temporary restarted alone");

   property p_step_seconds;
      q.step_sec_pend && !sec_carry
         |=> q.sec == ($past(q.step_dir)
            ? $past(q.sec) + {28'h0, $past(q.step_amt[3:0])}
            : $past(q.sec) - {28'h0, $past(q.step_amt[3:0])});
   endproperty
   a_step_seconds: assert property (p_step_seconds) else $error("seconds step wrong");

   property p_step_ns;
      q.step_ns_pend && ({1'b0, q.ns} + {1'b0, q.step_amt}) < pcra_pkg::NS_PER_SEC
         |=> q.ns == $past(q.ns) + $past(q.step_amt);
   endproperty
   a_step_ns: assert property (p_step_ns) else $error("ns step not added");

   property p_step_once;
      q.step_sec_pend && !bus_wr_en |=> !q.step_sec_pend;
   endproperty
   a_step_once: assert property (p_step_once) else $error("step applied twice");

   logic dur_wr;
   assign dur_wr = bus_wr_en && bus_addr == pcra_pkg::OFF_TEMPORARY_RATE_DURATION;

   property p_ns_step_once;
      q.step_ns_pend && !bus_wr_en |=> !q.step_ns_pend;
   endproperty
   a_ns_step_once: assert property (p_ns_step_once) else $error("ns step repeated");

   property p_sec_hold;
      !q.step_sec_pend && !sec_carry |=> q.sec == $past(q.sec);
   endproperty
   a_sec_hold: assert property (p_sec_hold) else $error("seconds moved alone");

   property p_reset_idle;
      $rose(i_rst_n) |-> !temp_active && !q.step_sec_pend && !q.step_ns_pend;
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("reset left work");

   property p_wrap_seen;
      wrap |=> q.subns < $past(q.subns);
   endproperty
   a_wrap_seen: assert property (p_wrap_seen) else $error("wrap not taken");

   property p_countdown;
      temp_active && !dur_wr |=> q.remain == $past(q.remain) - 32'h0000_0001;
   endproperty
   a_countdown: assert property (p_countdown) else $error("duration count wrong");

   property p_dur_load;
      dur_wr |=> q.remain == $past(bus_wr_data) && q.dur == $past(bus_wr_data);
   endproperty
   a_dur_load: assert property (p_dur_load) else $error("duration not loaded");

   property p_rate_load;
      bus_wr_en && bus_addr == pcra_pkg::OFF_RATE_ADJUST
         |=> q.rate_dir == $past(bus_wr_data[pcra_pkg::DIR_BIT])
            && q.rate_frac == $past(bus_wr_data[pcra_pkg::FRAC_W-1:0]);
   endproperty
   a_rate_load: assert property (p_rate_load) else $error("rate word not loaded");

   property p_temp_load;
      bus_wr_en && bus_addr == pcra_pkg::OFF_TEMPORARY_RATE_ADJUST
         |=> q.temp_dir == $past(bus_wr_data[pcra_pkg::DIR_BIT])
            && q.temp_frac == $past(bus_wr_data[pcra_pkg::FRAC_W-1:0]);
   endproperty
   a_temp_load: assert property (p_temp_load) else $error("temporary word not loaded");

   property p_step_load;
      bus_wr_en && bus_addr == pcra_pkg::OFF_STEP_ADJUST
         |=> q.step_dir == $past(bus_wr_data[pcra_pkg::DIR_BIT])
            && q.step_amt == $past(bus_wr_data[pcra_pkg::FRAC_W-1:0]);
   endproperty
   a_step_load: assert property (p_step_load) else $error("step word not loaded");
endmodule // pcra_rate_step

// File: bench/test_ptp_clock_rate_step_adjust.sv
`timescale 1ns/1ps
module test_ptp_clock_rate_step_adjust;
   logic i_clock;
   logic i_rst_n;
   logic clk_en;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic hready;
   logic hresp;
   logic [31:0] seconds;
   logic [29:0] nanoseconds;
   logic [31:0] subnanoseconds;
   logic temp_active;
   logic [31:0] rd_cap;
   logic [31:0] rd_val;
   int num_errors;
   int tests_run;
   int cnt;

   pcra_rate_step i_dut (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_clk_en(clk_en),
      .i_hsel(hsel),
      .i_haddr(haddr),
      .i_htrans(htrans),
      .i_hwrite(hwrite),
      .i_hsize(hsize),
      .i_hready(hready),
      .i_hwdata(hwdata),
      .o_hrdata(hrdata),
      .o_hreadyout(hready),
      .o_hresp(hresp),
      .o_seconds(seconds),
      .o_nanoseconds(nanoseconds),
      .o_subnanoseconds(subnanoseconds),
      .o_temporary_active(temp_active)
   );

   initial begin
      i_clock = 1'b0;
      forever #10 i_clock = ~i_clock;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Holds the current phase until hready is seen high at a rising edge
   task automatic wait_rdy;
      do @(posedge i_clock); while (hready !== 1'b1);
      rd_cap = hrdata;
   endtask

   task automatic bus_write(input logic [11:0] a, input logic [31:0] d);
      @(posedge i_clock);
      htrans <= pcra_pkg::HTRANS_NONSEQ_BIT;
      haddr <= {20'h0, a};
      hwrite <= 1'b1;
      wait_rdy;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy;
   endtask

   task automatic bus_read(input logic [11:0] a, output logic [31:0] d);
      @(posedge i_clock);
      htrans <= pcra_pkg::HTRANS_NONSEQ_BIT;
      haddr <= {20'h0, a};
      hwrite <= 1'b0;
      wait_rdy;
      htrans <= 2'h0;
      wait_rdy;
      d = rd_cap;
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      bus_read(a, rd_val);
      chk(rd_val, exp);
      chk({31'h0, hresp}, {31'h0, pcra_pkg::HRESP_OKAY});
   endtask

   // Compares n cycles of advance against fraction f and direction dir
   task automatic check_adv(input int n, input logic [31:0] f, input logic dir);
      logic [63:0] acc;
      logic [31:0] wr;
      logic [29:0] n0;
      logic [31:0] s0;
      @(negedge i_clock);
      n0 = nanoseconds;
      s0 = subnanoseconds;
      repeat (n) @(negedge i_clock);
      acc = {32'h0, s0} + 64'(n) * {32'h0, f};
      wr = acc[63:32];
      chk(subnanoseconds, acc[31:0]);
      chk({2'h0, nanoseconds}, {2'h0, n0} + 32'(pcra_pkg::REF_PERIOD_NS * n) + (dir ? wr : -wr));
   endtask

   task automatic do_step(input logic [31:0] adj, input logic [31:0] cmd,
                          input logic [31:0] dsec, input logic [29:0] dns);
      logic [31:0] s0;
      logic [29:0] n0;
      bus_write(pcra_pkg::OFF_STEP_ADJUST, adj);
      bus_write(pcra_pkg::OFF_STEP_CMD, cmd);
      @(negedge i_clock);
      s0 = seconds;
      n0 = nanoseconds;
      @(negedge i_clock);
      chk(seconds, s0 + dsec);
      chk({2'h0, nanoseconds}, {2'h0, n0 + dns});
      repeat (4) @(negedge i_clock);
      chk(seconds, s0 + dsec);
   endtask

   task automatic end_test(input string name);
      $display("test %s done, errors so far %0d", name, num_errors);
   endtask

   task automatic complete_run;
      $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge i_clock);
      num_errors++;
      complete_run;
   end

   initial begin
      i_rst_n = 1'b0;
      clk_en = 1'b1;
      hsel = 1'b1;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      num_errors = 0;
      tests_run = 0;
      repeat (8) @(posedge i_clock);
      i_rst_n <= 1'b1;
      // Reset values, reserved bit and an unmapped offset
      rd_chk(pcra_pkg::OFF_RATE_ADJUST, pcra_pkg::RESET_WORD);
      rd_chk(pcra_pkg::OFF_TEMPORARY_RATE_ADJUST, pcra_pkg::RESET_WORD);
      rd_chk(pcra_pkg::OFF_TEMPORARY_RATE_DURATION, pcra_pkg::RESET_WORD);
      rd_chk(pcra_pkg::OFF_STEP_ADJUST, pcra_pkg::RESET_WORD);
      rd_chk(12'h200, 32'h0);
      bus_write(pcra_pkg::OFF_RATE_ADJUST, 32'hffff_ffff);
      rd_chk(pcra_pkg::OFF_RATE_ADJUST, 32'hbfff_ffff);
      bus_write(pcra_pkg::OFF_RATE_ADJUST, 32'h0);
      end_test("registers");
      // Plain advance, then a frozen clock while the enable is low
      check_adv(20, 32'h0, 1'b0);
      @(posedge i_clock);
      clk_en <= 1'b0;
      @(negedge i_clock);
      cnt = int'(nanoseconds);
      repeat (3) @(negedge i_clock);
      chk({2'h0, nanoseconds}, 32'(cnt));
      @(posedge i_clock);
      clk_en <= 1'b1;
      end_test("nominal");
      // Permanent rate, slow then fast, one wrap every eight cycles
      bus_write(pcra_pkg::OFF_RATE_ADJUST, 32'h2000_0000);
      check_adv(64, 32'h2000_0000, 1'b0);
      bus_write(pcra_pkg::OFF_RATE_ADJUST, 32'ha000_0000);
      check_adv(64, 32'h2000_0000, 1'b1);
      bus_write(pcra_pkg::OFF_RATE_ADJUST, 32'h0);
      end_test("rate");
      // Temporary rate for sixteen cycles, then back to permanent
      bus_write(pcra_pkg::OFF_TEMPORARY_RATE_ADJUST, 32'hffff_ffff);
      rd_chk(pcra_pkg::OFF_TEMPORARY_RATE_ADJUST, 32'hbfff_ffff);
      bus_write(pcra_pkg::OFF_TEMPORARY_RATE_DURATION, 32'h10);
      check_adv(8, 32'h3fff_ffff, 1'b1);
      cnt = 0;
      while (temp_active === 1'b1 && cnt < 100) begin
         cnt++;
         @(negedge i_clock);
      end
      chk(32'(cnt), 32'h8);
      check_adv(16, 32'h0, 1'b0);
      rd_chk(pcra_pkg::OFF_TEMPORARY_RATE_DURATION, 32'h10);
      bus_write(pcra_pkg::OFF_TEMPORARY_RATE_ADJUST, 32'h1000_0000);
      bus_write(pcra_pkg::OFF_TEMPORARY_RATE_DURATION, 32'h40);
      check_adv(32, 32'h1000_0000, 1'b0);
      rd_chk(pcra_pkg::OFF_STEP_CMD, 32'h4);
      bus_write(pcra_pkg::OFF_TEMPORARY_RATE_DURATION, 32'h0);
      @(negedge i_clock);
      chk({31'h0, temp_active}, 32'h0);
      check_adv(16, 32'h0, 1'b0);
      bus_write(pcra_pkg::OFF_TEMPORARY_RATE_DURATION, 32'h2);
      @(negedge i_clock);
      cnt = 0;
      while (temp_active === 1'b1 && cnt < 100) begin
         cnt++;
         @(negedge i_clock);
      end
      chk(32'(cnt), 32'h2);
      end_test("temporary");
      // Steps: seconds add, seconds subtract, nanoseconds, both at once
      do_step(32'h8000_0013, 32'h1, 32'h3, 30'(pcra_pkg::REF_PERIOD_NS));
      do_step(32'h0000_0012, 32'h1, 32'hffff_fffe, 30'(pcra_pkg::REF_PERIOD_NS));
      do_step(32'h8000_1000, 32'h2, 32'h0, 30'h1000);
      do_step(32'h8000_0105, 32'h3, 32'h5, 30'h105);
      rd_chk(pcra_pkg::OFF_STEP_ADJUST, 32'h8000_0105);
      rd_chk(pcra_pkg::OFF_SECONDS, 32'h6);
      end_test("step");
      complete_run;
   end
endmodule // test_ptp_clock_rate_step_adjust
